// ---- hdl/paof_map.vh ----
/*
 * constants for the port alternate-function override block: pin indices,
 * reset values and the pad synchroniser depth.
 * assumes nothing; included by the synchroniser and top modules, not by the pin cell.
 */
`ifndef PAOF_MAP_VH
`define PAOF_MAP_VH

// =====================================================================
// port b pin positions
`define PAOF_PB_SS 0
`define PAOF_PB_SCK 1
`define PAOF_PB_MOSI 2
`define PAOF_PB_MISO 3
`define PAOF_PB_PINS 8

// =====================================================================
// port d and port e pin positions
`define PAOF_PD_CAPTURE 0
`define PAOF_PD_EXTIRQ 1
`define PAOF_PE_XCK 2
`define PAOF_PE_CLKOUT 7

// =====================================================================
// reset values and pad synchroniser depth
`define PAOF_RST_BYTE 8'h00
`define PAOF_RST_BIT 1'b0
`define PAOF_SYNC_STAGES 2

`endif

// ---- hdl/paof_sync.v ----
/*
 * two flip-flop synchroniser for a vector of pad levels.
 * assumes the pad inputs are asynchronous to clock.
 */
`timescale 1ns/1ps
`include "paof_map.vh"

module paof_sync #(
    parameter WIDTH = 8
) (
    // clock and reset
    input wire clock,
    input wire reset,
    // levels
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

reg [WIDTH-1:0] meta;

// =====================================================================
// first stage read only by the second
always @(posedge clock)
begin
    if (reset)
    begin
        meta <= {WIDTH{1'b0}};
        sync_out <= {WIDTH{1'b0}};
    end
    else
    begin
        meta <= async_in;
        sync_out <= meta;
    end
end

endmodule

// ---- hdl/paof_pin.v ----
/*
 * generic override cell for one port pin: resolves pull-up, output enable,
 * output value and digital input enable from the register bits and the
 * override signals of the alternate function.
 * assumes all inputs are on the same clock; purely combinational.
 */
`timescale 1ns/1ps

module paof_pin (
    // register bits
    input wire dir_bit,
    input wire out_bit,
    input wire global_pullup_disable,
    // overrides
    input wire puoe,
    input wire puov,
    input wire ddoe,
    input wire ddov,
    input wire pvoe,
    input wire pvov,
    input wire dieoe,
    input wire dieov,
    input wire sleep_input_enable,
    // resolved pad controls
    output wire pull_enable,
    output wire drive_enable,
    output wire drive_value,
    output wire input_enable
);

// =====================================================================
// override resolution
assign pull_enable = puoe ? puov : (~dir_bit & out_bit & ~global_pullup_disable);
assign drive_enable = ddoe ? ddov : dir_bit;
assign drive_value = pvoe ? pvov : out_bit;
assign input_enable = dieoe ? dieov : sleep_input_enable;

endmodule

// ---- hdl/paof_top.v ----
/*
 * port alternate-function override: serial-peripheral pins of port b,
 * pin-change sources of port b, external interrupt and capture pins of
 * port d, clock output and usart clock pins of port e.
 * assumes pads outside resolve the wire from drive enable and value, and
 * that peripherals synchronise nothing further themselves.
 */
`timescale 1ns/1ps
`include "paof_map.vh"

module paof_top (
    // clock and reset
    input wire clock,
    input wire reset,
    // port b register bits and pads
    input wire [7:0] dir_bit_portb,
    input wire [7:0] out_bit_portb,
    input wire [7:0] pad_in_portb,
    output reg [7:0] pad_oe_portb,
    output reg [7:0] pad_out_portb,
    output reg [7:0] pad_pullup_portb,
    output reg [7:0] pad_ie_portb,
    // global controls
    input wire global_pullup_disable,
    input wire sleep_active,
    // serial peripheral
    input wire serial_periph_enable,
    input wire serial_master_select,
    input wire spi_master_out,
    input wire spi_slave_out,
    input wire spi_clock_out,
    output reg spi_master_in,
    output reg spi_slave_in,
    output reg spi_clock_in,
    output reg spi_select_in,
    output reg spi_slave_active,
    // pin-change logic, group 1 is port b
    input wire [7:0] pin_change_mask_portb,
    input wire pin_change_group1_enable,
    output reg [7:0] pin_change_level_portb,
    // timer compare outputs on port b bits 7..4
    input wire [3:0] compare_enable,
    input wire [3:0] compare_value,
    // port d bits 1..0
    input wire [1:0] dir_bit_portd,
    input wire [1:0] out_bit_portd,
    input wire [1:0] pad_in_portd,
    input wire ext_irq_zero_enable,
    output reg [1:0] pad_oe_portd,
    output reg [1:0] pad_out_portd,
    output reg [1:0] pad_pullup_portd,
    output reg [1:0] pad_ie_portd,
    output reg ext_irq_zero,
    output reg capture_input_pin,
    // port e bits 7 and 2
    input wire dir_bit_porte_7,
    input wire out_bit_porte_7,
    input wire dir_bit_porte_2,
    input wire out_bit_porte_2,
    input wire [1:0] pad_in_porte,
    input wire clock_out_fuse,
    input wire divided_clock,
    input wire usart_sync_mode,
    input wire usart_clock_out,
    output reg pad_oe_porte_7,
    output reg pad_out_porte_7,
    output reg pad_oe_porte_2,
    output reg pad_out_porte_2,
    output reg [1:0] pad_pullup_porte,
    output reg usart_ext_clock_in,
    output reg usart_ext_clock_is_output
);

// =====================================================================
// pad input synchronisers
wire [7:0] sync_b;
wire [1:0] sync_d;
wire [1:0] sync_e;

paof_sync #(.WIDTH(12)) u_sync (
    .clock(clock),
    .reset(reset),
    .async_in({pad_in_porte, pad_in_portd, pad_in_portb}),
    .sync_out({sync_e, sync_d, sync_b})
);

// synchroniser holds real pad samples two edges after reset
reg [1:0] sync_fill;
wire sync_valid = (sync_fill == 2'h2);

always @(posedge clock)
begin
    if (reset)
    begin
        sync_fill <= 2'h0;
    end
    else if (!sync_valid)
    begin
        sync_fill <= sync_fill + 2'h1;
    end
end

// =====================================================================
// serial peripheral mode terms
wire spi_master = serial_periph_enable & serial_master_select;
wire spi_slave = serial_periph_enable & ~serial_master_select;

// =====================================================================
// port b override cells
wire [7:0] b_puoe;
wire [7:0] b_puov;
wire [7:0] b_ddoe;
wire [7:0] b_pvoe;
wire [7:0] b_pvov;
wire [7:0] b_dieoe;
wire [7:0] b_pullup;
wire [7:0] b_oe;
wire [7:0] b_out;
wire [7:0] b_ie;

genvar i;
generate
    for (i = 0; i < `PAOF_PB_PINS; i = i + 1)
    begin : g_portb
        // miso keeps its direction bit as slave
        if (i < 3)
        begin : g_spi
            // slave forces input, pull-up from the output bit
            assign b_puoe[i] = spi_slave;
            assign b_puov[i] = out_bit_portb[i] & ~global_pullup_disable;
            assign b_ddoe[i] = spi_slave;
        end
        else
        begin : g_cmp
            assign b_puoe[i] = 1'b0;
            assign b_puov[i] = 1'b0;
            assign b_ddoe[i] = 1'b0;
        end
        assign b_dieoe[i] = pin_change_mask_portb[i] & pin_change_group1_enable;
        paof_pin u_pin (
            .dir_bit(dir_bit_portb[i]),
            .out_bit(out_bit_portb[i]),
            .global_pullup_disable(global_pullup_disable),
            .puoe(b_puoe[i]),
            .puov(b_puov[i]),
            .ddoe(b_ddoe[i]),
            .ddov(1'b0),
            .pvoe(b_pvoe[i]),
            .pvov(b_pvov[i]),
            .dieoe(b_dieoe[i]),
            .dieov(1'b1),
            .sleep_input_enable(~sleep_active),
            .pull_enable(b_pullup[i]),
            .drive_enable(b_oe[i]),
            .drive_value(b_out[i]),
            .input_enable(b_ie[i])
        );
    end
endgenerate

// master drives sck and mosi, slave drives miso; compare outputs need direction set
assign b_pvoe[`PAOF_PB_SS] = 1'b0;
assign b_pvov[`PAOF_PB_SS] = 1'b0;
assign b_pvoe[`PAOF_PB_SCK] = spi_master;
assign b_pvov[`PAOF_PB_SCK] = spi_clock_out;
assign b_pvoe[`PAOF_PB_MOSI] = spi_master;
assign b_pvov[`PAOF_PB_MOSI] = spi_master_out;
assign b_pvoe[`PAOF_PB_MISO] = spi_slave;
assign b_pvov[`PAOF_PB_MISO] = spi_slave_out;
assign b_pvoe[7:4] = compare_enable;
assign b_pvov[7:4] = compare_value;

// =====================================================================
// port d override cells
wire [1:0] d_dieoe;
wire [1:0] d_pullup;
wire [1:0] d_oe;
wire [1:0] d_out;
wire [1:0] d_ie;

assign d_dieoe[`PAOF_PD_CAPTURE] = 1'b0;
assign d_dieoe[`PAOF_PD_EXTIRQ] = ext_irq_zero_enable;

generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_portd
        paof_pin u_pin (
            .dir_bit(dir_bit_portd[i]),
            .out_bit(out_bit_portd[i]),
            .global_pullup_disable(global_pullup_disable),
            .puoe(1'b0),
            .puov(1'b0),
            .ddoe(1'b0),
            .ddov(1'b0),
            .pvoe(1'b0),
            .pvov(1'b0),
            .dieoe(d_dieoe[i]),
            .dieov(1'b1),
            .sleep_input_enable(~sleep_active),
            .pull_enable(d_pullup[i]),
            .drive_enable(d_oe[i]),
            .drive_value(d_out[i]),
            .input_enable(d_ie[i])
        );
    end
endgenerate

// =====================================================================
// port e override cells, index 1 is bit 7 and index 0 is bit 2
wire xck_out_en = usart_sync_mode & dir_bit_porte_2;
wire [1:0] e_dir;
wire [1:0] e_outb;
wire [1:0] e_ovr;
wire [1:0] e_pvoe;
wire [1:0] e_pvov;
wire [1:0] e_pullup;
wire [1:0] e_oe;
wire [1:0] e_out;

assign e_dir = {dir_bit_porte_7, dir_bit_porte_2};
assign e_outb = {out_bit_porte_7, out_bit_porte_2};
assign e_ovr = {clock_out_fuse, 1'b0};
assign e_pvoe = {clock_out_fuse, xck_out_en};
assign e_pvov = {divided_clock, usart_clock_out};

generate
    for (i = 0; i < 2; i = i + 1)
    begin : g_porte
        paof_pin u_pin (
            .dir_bit(e_dir[i]),
            .out_bit(e_outb[i]),
            .global_pullup_disable(global_pullup_disable),
            .puoe(e_ovr[i]),
            .puov(1'b0),
            .ddoe(e_ovr[i]),
            .ddov(1'b1),
            .pvoe(e_pvoe[i]),
            .pvov(e_pvov[i]),
            .dieoe(1'b0),
            .dieov(1'b0),
            .sleep_input_enable(~sleep_active),
            .pull_enable(e_pullup[i]),
            .drive_enable(e_oe[i]),
            .drive_value(e_out[i]),
            .input_enable()
        );
    end
endgenerate

// =====================================================================
// registered outputs; clock output pin is not reset
always @(posedge clock)
begin
    if (reset)
    begin
        pad_oe_portb <= `PAOF_RST_BYTE;
        pad_out_portb <= `PAOF_RST_BYTE;
        pad_pullup_portb <= `PAOF_RST_BYTE;
        pad_ie_portb <= `PAOF_RST_BYTE;
        spi_master_in <= `PAOF_RST_BIT;
        spi_slave_in <= `PAOF_RST_BIT;
        spi_clock_in <= `PAOF_RST_BIT;
        spi_select_in <= 1'b1;
        spi_slave_active <= `PAOF_RST_BIT;
        pin_change_level_portb <= `PAOF_RST_BYTE;
        pad_oe_portd <= 2'h0;
        pad_out_portd <= 2'h0;
        pad_pullup_portd <= 2'h0;
        pad_ie_portd <= 2'h0;
        ext_irq_zero <= `PAOF_RST_BIT;
        capture_input_pin <= `PAOF_RST_BIT;
        pad_oe_porte_2 <= `PAOF_RST_BIT;
        pad_out_porte_2 <= `PAOF_RST_BIT;
        pad_pullup_porte <= 2'h0;
        usart_ext_clock_in <= `PAOF_RST_BIT;
        usart_ext_clock_is_output <= `PAOF_RST_BIT;
    end
    else
    begin
        pad_oe_portb <= b_oe;
        pad_out_portb <= b_out;
        pad_pullup_portb <= b_pullup;
        pad_ie_portb <= b_ie;
        spi_master_in <= spi_master & sync_b[`PAOF_PB_MISO];
        spi_slave_in <= spi_slave & sync_b[`PAOF_PB_MOSI];
        spi_clock_in <= spi_slave & sync_b[`PAOF_PB_SCK];
        spi_select_in <= sync_b[`PAOF_PB_SS] | ~sync_valid;
        spi_slave_active <= spi_slave & sync_valid & ~sync_b[`PAOF_PB_SS];
        pin_change_level_portb <= sync_b;
        pad_oe_portd <= d_oe;
        pad_out_portd <= d_out;
        pad_pullup_portd <= d_pullup;
        pad_ie_portd <= d_ie;
        ext_irq_zero <= sync_d[`PAOF_PD_EXTIRQ];
        capture_input_pin <= sync_d[`PAOF_PD_CAPTURE];
        pad_oe_porte_2 <= e_oe[0];
        pad_out_porte_2 <= e_out[0];
        pad_pullup_porte <= e_pullup;
        usart_ext_clock_in <= usart_sync_mode & ~dir_bit_porte_2 & sync_e[0];
        usart_ext_clock_is_output <= xck_out_en;
    end
end

// fuse path ignores reset so the clock keeps running
always @(posedge clock)
begin
    pad_oe_porte_7 <= e_oe[1];
    pad_out_porte_7 <= e_out[1];
end

endmodule

// ---- sim/paof_top_assertions.sv ----
/* port-level assertions for paof_top.
   assumes binding onto paof_top; reset synchronous, active high. */
`timescale 1ns/1ps
module paof_top_chk (
    // clock and reset
    input wire clock,
    input wire reset,
    // controls
    input wire serial_periph_enable,
    input wire serial_master_select,
    input wire [7:0] dir_bit_portb,
    input wire [7:0] out_bit_portb,
    input wire global_pullup_disable,
    input wire spi_master_out,
    input wire spi_clock_out,
    input wire clock_out_fuse,
    input wire divided_clock,
    input wire usart_sync_mode,
    input wire dir_bit_porte_2,
    // pads
    input wire [7:0] pad_in_portb,
    input wire [1:0] pad_in_portd,
    input wire [7:0] pad_oe_portb,
    input wire [7:0] pad_out_portb,
    input wire [7:0] pad_pullup_portb,
    input wire pad_oe_porte_7,
    input wire pad_out_porte_7,
    // peripheral side
    input wire spi_slave_active,
    input wire ext_irq_zero,
    input wire capture_input_pin,
    input wire [7:0] pin_change_level_portb,
    input wire usart_ext_clock_is_output
);
    // ==========================================
    // edges since reset release
    reg [2:0] settle;
    wire slave = serial_periph_enable & ~serial_master_select;
    always @(posedge clock)
    begin
        if (reset)
            settle <= 3'h0;
        else if (settle != 3'h4)
            settle <= settle + 3'h1;
    end
    default clocking cb @(posedge clock); endclocking
    // ==========================================
    // properties
    chk_slave_forced_in: assert property (disable iff (reset)
        slave |=> pad_oe_portb[2:0] == 3'h0) else $error("slave pins not inputs");
    chk_forced_pullup: assert property (disable iff (reset)
        slave |=> pad_pullup_portb[2:0] == ($past(out_bit_portb[2:0])
        & {3{!$past(global_pullup_disable)}})) else $error("forced pin pull-up wrong");
    chk_select_gates: assert property (disable iff (reset)
        spi_slave_active |-> !$past(pad_in_portb[0], 3) && $past(slave))
        else $error("slave active without select low");
    chk_master_drives: assert property (disable iff (reset)
        serial_periph_enable && serial_master_select |=> pad_out_portb[2:1]
        == $past({spi_master_out, spi_clock_out})) else $error("master values not driven");
    chk_input_levels: assert property (disable iff (reset)
        settle == 3'h4 |-> {ext_irq_zero, capture_input_pin, pin_change_level_portb}
        == $past({pad_in_portd, pad_in_portb}, 3)) else $error("pad level not delivered");
    chk_clock_out_fuse: assert property (
        clock_out_fuse |=> pad_oe_porte_7 && pad_out_porte_7 == $past(divided_clock))
        else $error("divided clock not on pin");
    chk_usart_clock_dir: assert property (disable iff (reset)
        settle != 3'h0 |-> usart_ext_clock_is_output
        == $past(usart_sync_mode && dir_bit_porte_2)) else $error("usart clock direction wrong");
    chk_idle_pullup: assert property (disable iff (reset)
        settle != 3'h0 && !$past(serial_periph_enable) |-> pad_pullup_portb[2:0]
        == $past(~dir_bit_portb[2:0] & out_bit_portb[2:0] & {3{~global_pullup_disable}}))
        else $error("plain pull-up wrong");
    cover property (disable iff (reset) $rose(spi_slave_active));
    cover property (disable iff (reset) serial_periph_enable && serial_master_select);
    cover property (clock_out_fuse && reset);
endmodule

bind paof_top paof_top_chk chk (.*);

// ---- sim/paof_pads.sv ----
/* pad model for a group of port pins: device drive wins, then an outside
   driver, then the pull-up; a free pin wobbles every cycle.
   assumes device pad controls are registered on clock. */
`timescale 1ns/1ps
module paof_pads #(
    parameter W = 8
) (
    // clock
    input wire clock,
    // device side
    input wire [W-1:0] oe,
    input wire [W-1:0] drive,
    input wire [W-1:0] pull_enable,
    // outside driver
    input wire [W-1:0] ext,
    input wire [W-1:0] ext_en,
    // pad level
    output wire [W-1:0] level
);
    reg [W-1:0] wobble = {W{1'b0}};
    always @(posedge clock)
        wobble <= ~wobble;
    assign level = (oe & drive) | (~oe & ((ext_en & ext) | (~ext_en & (pull_enable | wobble))));
endmodule

// ---- sim/testbench.sv ----
/* self-checking bench for paof_top with pad models on ports b and d.
   assumes the design's hand-over latencies: 1 edge control, 3 edges pads. */
`timescale 1ns/1ps
module testbench;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic [7:0] dir_bit_portb, out_bit_portb, pin_change_mask_portb, ext_b, en_b, m, lv;
    logic global_pullup_disable, sleep_active, serial_periph_enable, serial_master_select;
    logic spi_master_out, spi_slave_out, spi_clock_out, pin_change_group1_enable, slave;
    logic [3:0] compare_enable, compare_value;
    logic [1:0] dir_bit_portd, out_bit_portd, ext_d, pad_in_porte;
    logic ext_irq_zero_enable, dir_bit_porte_7, out_bit_porte_7, dir_bit_porte_2;
    logic out_bit_porte_2, clock_out_fuse, divided_clock, usart_sync_mode, usart_clock_out;
    logic [31:0] e;
    logic [95:0] rnd;
    wire [7:0] pad_in_portb, pad_oe_portb, pad_out_portb, pad_pullup_portb, pad_ie_portb;
    wire [7:0] pin_change_level_portb;
    wire [1:0] pad_in_portd, pad_oe_portd, pad_out_portd, pad_pullup_portd, pad_ie_portd;
    wire [1:0] pad_pullup_porte;
    wire spi_master_in, spi_slave_in, spi_clock_in, spi_select_in, spi_slave_active;
    wire ext_irq_zero, capture_input_pin, pad_oe_porte_7, pad_out_porte_7, pad_oe_porte_2;
    wire pad_out_porte_2, usart_ext_clock_in, usart_ext_clock_is_output;
    int seed, i, err_count = 0, check_count = 0, cycles = 0;

    paof_top DUT (.*);
    paof_pads #(.W(8)) pads_b (.clock(clock), .oe(pad_oe_portb), .drive(pad_out_portb),
        .pull_enable(pad_pullup_portb), .ext(ext_b), .ext_en(en_b), .level(pad_in_portb));
    paof_pads #(.W(2)) pads_d (.clock(clock), .oe(pad_oe_portd), .drive(pad_out_portd),
        .pull_enable(pad_pullup_portd), .ext(ext_d), .ext_en(2'h3), .level(pad_in_portd));

    initial
    begin
        forever #10 clock = ~clock;
    end

    // ==========================================
    // tasks
    task complete_run();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task drive(input logic [72:0] v);
        {dir_bit_portb, out_bit_portb, pin_change_mask_portb, ext_b, en_b,
            global_pullup_disable, sleep_active, serial_periph_enable, serial_master_select,
            spi_master_out, spi_slave_out, spi_clock_out, pin_change_group1_enable,
            compare_enable, compare_value, dir_bit_portd, out_bit_portd, ext_d, pad_in_porte,
            ext_irq_zero_enable, dir_bit_porte_7, out_bit_porte_7, dir_bit_porte_2,
            out_bit_porte_2, clock_out_fuse, usart_sync_mode, usart_clock_out,
            divided_clock} = v;
    endtask

    // port b pad controls {oe, pullup, out, ie}
    function automatic logic [31:0] exp_b();
        logic [7:0] oe, o;
        oe = dir_bit_portb & ~{5'h0, {3{slave}}};
        o = {(compare_enable & compare_value) | (~compare_enable & out_bit_portb[7:4]),
            out_bit_portb[3:0]};
        if (serial_periph_enable & serial_master_select)
            o[2:1] = {spi_master_out, spi_clock_out};
        if (slave)
            o[3] = spi_slave_out;
        return {oe, ~oe & out_bit_portb & {8{~global_pullup_disable}},
            o & oe, (pin_change_mask_portb & {8{pin_change_group1_enable}})
            | {8{~sleep_active}}};
    endfunction

    // ==========================================
    // timeout
    always @(posedge clock)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            err_count++;
            complete_run();
        end
    end

    // ==========================================
    // main sequence
    initial
    begin
        seed = 32'h21ed;
        // fuse programmed, every other input clear
        drive(73'h8);
        repeat (20)
        begin
            @(negedge clock);
            check({pad_oe_porte_7, pad_out_porte_7}, {1'b1, divided_clock});
            divided_clock = ~divided_clock;
        end
        reset = 1'b0;
        for (i = 0; i < 300; i++)
        begin
            rnd = {$random(seed), $random(seed), $random(seed)};
            if (i < 6)
            begin
                // slave or master, every port b direction bit set, select pad driven outside
                rnd[72:65] = 8'hff;
                rnd[41] = i[0];
                rnd[33] = 1'b1;
                rnd[30:29] = {1'b1, i[2]};
            end
            drive(rnd[72:0]);
            slave = serial_periph_enable & ~serial_master_select;
            repeat (5) @(negedge clock);
            e = exp_b();
            check({pad_oe_portb, pad_pullup_portb, pad_out_portb & pad_oe_portb, pad_ie_portb},
                e);
            m = ~(e[31:24] | (dir_bit_portb & 8'h08)) & (en_b | e[23:16]);
            lv = (en_b & ext_b) | (~en_b & e[23:16]);
            check(pin_change_level_portb & m, lv & m);
            if (m[0] | ~slave)
                check(spi_slave_active, slave & ~lv[0]);
            if (slave & m[2])
                check(spi_slave_in, lv[2]);
            if (m[0])
                check(spi_select_in, lv[0]);
            if (m[1] | ~slave)
                check(spi_clock_in, slave & lv[1]);
            if (m[3] | ~(serial_periph_enable & serial_master_select))
                check(spi_master_in, serial_periph_enable & serial_master_select & lv[3]);
            check({pad_ie_portd, pad_pullup_portd, pad_pullup_porte},
                {ext_irq_zero_enable | ~sleep_active, ~sleep_active,
                ~dir_bit_portd & out_bit_portd & {2{~global_pullup_disable}},
                ~dir_bit_porte_7 & out_bit_porte_7 & ~global_pullup_disable & ~clock_out_fuse,
                ~dir_bit_porte_2 & out_bit_porte_2 & ~global_pullup_disable});
            check({ext_irq_zero, capture_input_pin},
                (dir_bit_portd & out_bit_portd) | (~dir_bit_portd & ext_d));
            check(pad_oe_porte_7, clock_out_fuse | dir_bit_porte_7);
            if (clock_out_fuse | dir_bit_porte_7)
                check(pad_out_porte_7, clock_out_fuse ? divided_clock : out_bit_porte_7);
            check({usart_ext_clock_is_output, usart_ext_clock_in, pad_oe_porte_2},
                {usart_sync_mode & dir_bit_porte_2, usart_sync_mode & ~dir_bit_porte_2
                & pad_in_porte[0], dir_bit_porte_2});
            if (dir_bit_porte_2)
                check(pad_out_porte_2, usart_sync_mode ? usart_clock_out : out_bit_porte_2);
        end
        complete_run();
    end
endmodule
